// ### pvc_pkg.sv
// register map constants for the vendor control register bank
package pvc_pkg;
  localparam logic [4:0]  ADDR_DIGITAL_MISC   = 5'h10;
  localparam logic [4:0]  ADDR_AFE_CONTROL    = 5'h11;
  localparam logic [4:0]  ADDR_SYMERR_COUNT   = 5'h15;
  localparam logic [4:0]  ADDR_STRAP_OVERRIDE = 5'h16;
  localparam logic [15:0] RESET_DIGITAL_MISC  = 16'h0000;
  localparam logic [15:0] RESET_AFE_CONTROL   = 16'h0000;
  localparam logic [15:0] RESET_SYMERR_COUNT  = 16'h0000;
  localparam logic [15:0] RESET_STRAP_LOW     = 16'h0001;
  localparam int          BIT_PLL_OFF         = 4;
  localparam int          BIT_SLOW_OSC        = 5;
  localparam int          BIT_WAKE_EN         = 15;
  localparam int          BIT_RO_RESERVED     = 10;
  localparam int          BIT_BCAST_DISABLE   = 9;
  localparam logic [15:0] STRAP_WRITE_MASK    = 16'hfbff;
endpackage

// ### pvc_if.sv
// counter control signals between the register bank and its counter
`timescale 1ns/1ps
`default_nettype none
interface pvc_count_if;
  logic        incr;
  logic        clear;
  logic [15:0] value;
  modport bank (output incr, output clear, input value);
  modport counter (input incr, input clear, output value);
endinterface
`default_nettype wire

// ### pvc_symerr_counter.sv
// self-clearing saturating error frame counter
`timescale 1ns/1ps
`default_nettype none
module pvc_symerr_counter
(
  input  wire logic     clock,
  input  wire logic     rst_n,
  pvc_count_if.counter  cnt
);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cnt.value <= pvc_pkg::RESET_SYMERR_COUNT;
    else if (cnt.clear)
      // an event in the clearing cycle starts the new count
      cnt.value <= {15'h0000, cnt.incr};
    else if (cnt.incr && cnt.value != 16'hffff)
      cnt.value <= cnt.value + 16'h0001;
  end
endmodule
`default_nettype wire

// ### pvc_vendor_regs.sv
// vendor control register bank of the ethernet phy
// Operation
// - pll shutdown bit lets pll stop during energy-detect power-down; reset clear
// - slow-oscillator bit disconnects crystal input, selects internal oscillator
// - slow-oscillator bit also forces analog software power-down
// - sixteen-bit received symbol-error frame counter, reset zero
// - counter read-only; a read returns count then restarts it
// - wake enable gates event output; reset from strap; EVENT_PIN_SELECT[1] selects pin
// - broadcast override stops address zero acting as broadcast
`timescale 1ns/1ps
`default_nettype none
module pvc_vendor_regs
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  input  wire logic        WAKE_EVENT_STRAP,
  input  wire logic        ENERGY_DETECT_POWER_DOWN,
  input  wire logic        RECEIVE_SYMBOL_ERROR_FRAME,
  input  wire logic        POWER_MGMT_EVENT_IN,
  input  wire logic [1:0]  EVENT_PIN_SELECT,
  input  wire logic        BROADCAST_ADDR_DISABLE_STRAP,
  output logic             PLL_STOP,
  output logic             SLOW_OSC_SELECT,
  output logic             CRYSTAL_INPUT_DISCONNECT,
  output logic             ANALOG_FRONTEND_POWER_DOWN,
  output logic             POWER_MGMT_EVENT_PIN21,
  output logic             POWER_MGMT_EVENT_PIN30,
  output logic             BROADCAST_ADDR_DISABLE
);
  logic [15:0] digital_misc_control;
  logic [15:0] analog_frontend_control;
  logic [15:0] strap_override_control;
  logic        strap_meta;
  logic        strap_sync;
  logic        bcast_meta;
  logic        bcast_sync;
  logic        energy_detect_power_down_meta;
  logic        energy_detect_power_down_sync;
  logic        rxerr_meta;
  logic        rxerr_sync;
  logic        rxerr_prev;
  logic [1:0]  strap_settle;
  logic        wake_gated;
  pvc_count_if cnt ();

  // strap, energy-detect and error-frame pins pass two flip-flops before any logic looks at them
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
      bcast_meta <= 1'b0;
      bcast_sync <= 1'b0;
      energy_detect_power_down_meta  <= 1'b0;
      energy_detect_power_down_sync  <= 1'b0;
      rxerr_meta <= 1'b0;
      rxerr_sync <= 1'b0;
    end
    else
    begin
      strap_meta <= WAKE_EVENT_STRAP;
      strap_sync <= strap_meta;
      bcast_meta <= BROADCAST_ADDR_DISABLE_STRAP;
      bcast_sync <= bcast_meta;
      energy_detect_power_down_meta  <= ENERGY_DETECT_POWER_DOWN;
      energy_detect_power_down_sync  <= energy_detect_power_down_meta;
      rxerr_meta <= RECEIVE_SYMBOL_ERROR_FRAME;
      rxerr_sync <= rxerr_meta;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      rxerr_prev <= 1'b0;
    else
      rxerr_prev <= rxerr_sync;
  end

  // reserved bits are stored but drive nothing
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      digital_misc_control <= pvc_pkg::RESET_DIGITAL_MISC;
    else if (REG_WR && REG_ADDR == pvc_pkg::ADDR_DIGITAL_MISC)
      digital_misc_control <= REG_WDATA;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      analog_frontend_control <= pvc_pkg::RESET_AFE_CONTROL;
    else if (REG_WR && REG_ADDR == pvc_pkg::ADDR_AFE_CONTROL)
      analog_frontend_control <= REG_WDATA;
  end

  // wake enable follows the second sync stage until the pipe has filled,
  // so the stale reset value of the synchroniser is never latched
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      strap_override_control <= pvc_pkg::RESET_STRAP_LOW;
      strap_settle           <= 2'h0;
    end
    else if (strap_settle != 2'h3)
    begin
      strap_settle <= strap_settle + 2'h1;
      strap_override_control[pvc_pkg::BIT_WAKE_EN] <= strap_sync;
    end
    else if (REG_WR && REG_ADDR == pvc_pkg::ADDR_STRAP_OVERRIDE)
      strap_override_control <= REG_WDATA & pvc_pkg::STRAP_WRITE_MASK;
  end

  // counter events and read clear
  assign cnt.incr  = rxerr_sync && !rxerr_prev;
  assign cnt.clear = REG_RD && REG_ADDR == pvc_pkg::ADDR_SYMERR_COUNT;

  pvc_symerr_counter u_counter
  (
    .clock (CLOCK),
    .rst_n (RST_N),
    .cnt   (cnt)
  );

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      REG_RDATA <= 16'h0000;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        pvc_pkg::ADDR_DIGITAL_MISC:   REG_RDATA <= digital_misc_control;
        pvc_pkg::ADDR_AFE_CONTROL:    REG_RDATA <= analog_frontend_control;
        pvc_pkg::ADDR_SYMERR_COUNT:   REG_RDATA <= cnt.value;
        pvc_pkg::ADDR_STRAP_OVERRIDE: REG_RDATA <= strap_override_control;
        default:                      REG_RDATA <= 16'h0000;
      endcase
    end
  end

  assign wake_gated = strap_override_control[pvc_pkg::BIT_WAKE_EN]
                      && POWER_MGMT_EVENT_IN;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      PLL_STOP                   <= 1'b0;
      SLOW_OSC_SELECT            <= 1'b0;
      CRYSTAL_INPUT_DISCONNECT   <= 1'b0;
      ANALOG_FRONTEND_POWER_DOWN <= 1'b0;
      POWER_MGMT_EVENT_PIN21     <= 1'b0;
      POWER_MGMT_EVENT_PIN30     <= 1'b0;
      BROADCAST_ADDR_DISABLE     <= 1'b0;
    end
    else
    begin
      PLL_STOP <= digital_misc_control[pvc_pkg::BIT_PLL_OFF]
                  && energy_detect_power_down_sync;
      SLOW_OSC_SELECT <= analog_frontend_control[pvc_pkg::BIT_SLOW_OSC];
      CRYSTAL_INPUT_DISCONNECT <=
        analog_frontend_control[pvc_pkg::BIT_SLOW_OSC];
      ANALOG_FRONTEND_POWER_DOWN <=
        analog_frontend_control[pvc_pkg::BIT_SLOW_OSC];
      POWER_MGMT_EVENT_PIN21 <= wake_gated && !EVENT_PIN_SELECT[1];
      POWER_MGMT_EVENT_PIN30 <= wake_gated && EVENT_PIN_SELECT[1];
      BROADCAST_ADDR_DISABLE <=
        strap_override_control[pvc_pkg::BIT_BCAST_DISABLE]
        || bcast_sync;
    end
  end
endmodule
`default_nettype wire

// ### pvc_vendor_regs_monitor.sv
// assertion checker for the vendor register bank ports
`timescale 1ns/1ps
`default_nettype none
module pvc_vendor_regs_monitor
(
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [4:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic        POWER_MGMT_EVENT_IN,
  input wire logic        PLL_STOP,
  input wire logic        SLOW_OSC_SELECT,
  input wire logic        ANALOG_FRONTEND_POWER_DOWN,
  input wire logic        BROADCAST_ADDR_DISABLE,
  input wire logic        POWER_MGMT_EVENT_PIN21,
  input wire logic        POWER_MGMT_EVENT_PIN30
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  pll_hold_a: assert property (REG_WR && REG_ADDR == 5'h10
    && !REG_WDATA[4] ##1 !REG_WR |=> !PLL_STOP) else $error("pll stopped");
  slow_osc_a: assert property (REG_WR && REG_ADDR == 5'h11 ##1 !REG_WR
    |=> SLOW_OSC_SELECT == $past(REG_WDATA[5], 2)) else $error("slow osc");
  analog_pd_tie_a: assert property (ANALOG_FRONTEND_POWER_DOWN
    == SLOW_OSC_SELECT) else $error("analog power-down");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
  wake_gate_a: assert property (!POWER_MGMT_EVENT_IN |=>
    !POWER_MGMT_EVENT_PIN21 && !POWER_MGMT_EVENT_PIN30) else $error("event");
  bcast_force_a: assert property (REG_WR && REG_ADDR == 5'h16
    && REG_WDATA[9] ##1 !REG_WR |=> BROADCAST_ADDR_DISABLE) else $error("bc");
  ro_bit_zero_a: assert property (REG_RD && REG_ADDR == 5'h16
    |=> !REG_RDATA[10]) else $error("read-only bit set");
  unmapped_zero_a: assert property (REG_RD && !(REG_ADDR inside
    {5'h10, 5'h11, 5'h15, 5'h16}) |=> REG_RDATA == 16'h0000) else $error("um");
endmodule
bind pvc_vendor_regs pvc_vendor_regs_monitor pvc_vendor_regs_monitor_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .POWER_MGMT_EVENT_IN(POWER_MGMT_EVENT_IN), .PLL_STOP(PLL_STOP),
  .SLOW_OSC_SELECT(SLOW_OSC_SELECT),
  .BROADCAST_ADDR_DISABLE(BROADCAST_ADDR_DISABLE),
  .ANALOG_FRONTEND_POWER_DOWN(ANALOG_FRONTEND_POWER_DOWN),
  .POWER_MGMT_EVENT_PIN21(POWER_MGMT_EVENT_PIN21),
  .POWER_MGMT_EVENT_PIN30(POWER_MGMT_EVENT_PIN30));
`default_nettype wire

// ### pvc_mgmt_model.sv
// management controller model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pvc_mgmt_model
(
  input  wire logic        clock,
  output logic      [4:0]  addr,
  output logic             wr,
  output logic             rd,
  output logic      [15:0] wdata,
  input  wire logic [15:0] rdata
);
  initial {addr, wr, rd, wdata} = '0;
  task automatic access(input logic w, input logic [4:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    @(posedge clock) #1;
    {addr, wr, rd, wdata} = {a, w, !w, d};
    @(posedge clock) #1;
    // released address and data lines show the inverse so stale values cannot pass
    {addr, wr, rd, wdata} = {~a, 2'b00, ~d};
    @(posedge clock) #1;
    q = rdata;
  endtask
endmodule
`default_nettype wire

// ### pvc_vendor_regs_tb.sv
// testbench comparing the vendor register bank with a bench model
`timescale 1ns/1ps
`default_nettype none
module pvc_vendor_regs_tb;
  logic        CLOCK = 0, RST_N = 0, energy_detect_power_down = 0, rxe = 0, power_mgmt_event = 0;
  logic        wstrap = 0, bstrap = 0, wr, rd, pll, slow, xdis, apd, p21, p30, bc;
  logic [1:0]  psel = 0;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, q;
  logic [15:0] m [32];
  logic [4:0]  al [5] = '{5'h10, 5'h11, 5'h15, 5'h16, 5'h1f};
  int          bad_count = 0, n_compared = 0, cnt = 0, k;
  always #2 CLOCK = ~CLOCK;
  pvc_mgmt_model pvc_mgmt_model_i (.clock(CLOCK), .addr(addr), .wr(wr),
    .rd(rd), .wdata(wdata), .rdata(rdata));
  pvc_vendor_regs pvc_vendor_regs_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .WAKE_EVENT_STRAP(wstrap), .ENERGY_DETECT_POWER_DOWN(energy_detect_power_down),
    .RECEIVE_SYMBOL_ERROR_FRAME(rxe), .POWER_MGMT_EVENT_IN(power_mgmt_event),
    .EVENT_PIN_SELECT(psel), .BROADCAST_ADDR_DISABLE_STRAP(bstrap),
    .PLL_STOP(pll), .SLOW_OSC_SELECT(slow), .CRYSTAL_INPUT_DISCONNECT(xdis),
    .ANALOG_FRONTEND_POWER_DOWN(apd), .POWER_MGMT_EVENT_PIN21(p21),
    .POWER_MGMT_EVENT_PIN30(p30), .BROADCAST_ADDR_DISABLE(bc));
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    pvc_mgmt_model_i.access(w, a, d, q);
    if (w && a inside {5'h10, 5'h11}) m[a] = d;
    if (w && a == 5'h16) m[a] = d & 16'hfbff;
    if (!w) chk(q, a == 5'h15 ? cnt[15:0] : m[a]);
    if (!w && a == 5'h15) cnt = 0;
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    bad_count++;
    close_out;
  end
  initial
  begin
    k = $urandom(32'hc718c16e);
    wstrap = $urandom;
    foreach (m[j]) m[j] = 16'h0000;
    m[22] = {wstrap, 15'h0001};
    repeat (2) @(posedge CLOCK);
    #1 RST_N = 1;
    repeat (4) @(posedge CLOCK);
    foreach (al[j]) acc(0, al[j], 0);
    $display("reset values done");
    for (int i = 0; i < 6; i++)
    begin
      foreach (al[j]) acc(1, al[j], $urandom);
      {energy_detect_power_down, bstrap, power_mgmt_event, psel} = 5'($urandom);
      repeat (4) @(posedge CLOCK);
      chk(pll, m[16][4] & energy_detect_power_down);
      chk({slow, xdis, apd}, {3{m[17][5]}});
      chk(bc, m[22][9] | bstrap);
      chk({p30, p21}, {2{power_mgmt_event & m[22][15]}} & (psel[1] ? 2'b10 : 2'b01));
      repeat ($urandom_range(1, 5))
      begin
        rxe = 1;
        repeat (2) @(posedge CLOCK) #1;
        rxe = 0;
        repeat (2) @(posedge CLOCK) #1;
        cnt++;
      end
      repeat (4) @(posedge CLOCK);
      foreach (al[j]) acc(0, al[j], 0);
      acc(0, 5'h15, 0);
      $display("pass %0d done", i);
    end
    close_out;
  end
endmodule
`default_nettype wire
